// ==== common/atcc_pkg.sv ====
// constants and types shared by the trigger and sampling clock control block
`default_nettype none
package atcc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CHAN_N = 4;
   localparam int DIV_W = 16;
   localparam int MODE_W = 3;
   localparam int LEVEL_W = 8;
   localparam int ORIGIN_W = 3;
   localparam int COUNT_W = 16;
   // register offsets
   localparam logic [7:0] OFF_CHAN = 8'h00;
   localparam logic [7:0] OFF_DIV = 8'h04;
   localparam logic [7:0] OFF_MODE = 8'h08;
   localparam logic [7:0] OFF_LEVEL = 8'h0c;
   localparam logic [7:0] OFF_ORIGIN = 8'h10;
   localparam logic [7:0] OFF_COUNT = 8'h14;
   // field positions
   localparam int CHAN_LSB = 0;
   localparam int DIV_LSB = 0;
   localparam int MODE_LSB = 0;
   localparam int LEVEL_LSB = 0;
   localparam int ORIGIN_LSB = 0;
   localparam int SLOPE_BIT = 3;
   localparam int EXT_SEL_BIT = 2;
   localparam int COUNT_LSB = 0;
   // reset values
   localparam logic [3:0] RST_CHAN = 4'h0;
   localparam logic [15:0] RST_DIV = 16'h0002;
   localparam logic [7:0] RST_LEVEL = 8'h80;
   localparam logic [2:0] RST_ORIGIN = 3'h0;
   localparam logic RST_SLOPE = 1'b0;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [31:0] READ_VALUE = 32'h0000_0000;
   typedef enum logic [2:0] {
      MODE_SOFT   = 3'h0,
      MODE_POST   = 3'h1,
      MODE_PRE    = 3'h2,
      MODE_DELAY  = 3'h3,
      MODE_MIDDLE = 3'h4
   } atcc_mode_t;
endpackage
`default_nettype wire

// ==== common/atcc_div_if.sv ====
// divisor and sampling clock between the control core and the divider
`timescale 1ns/1ps
`default_nettype none
interface atcc_div_if;
   logic [15:0] divisor;
   logic        sample_clk;
   logic        sample_tick;
   modport ctrl (output divisor, input sample_clk, input sample_tick);
   modport gen (input divisor, output sample_clk, output sample_tick);
endinterface
`default_nettype wire

// ==== logic/atcc_sample_divider.sv ====
// programmable divider that makes the sampling clock from the source clock
`timescale 1ns/1ps
`default_nettype none
module atcc_sample_divider (
   input  wire logic clk,
   input  wire logic rst,
   atcc_div_if.gen   div
);
   import atcc_pkg::*;

   logic [14:0] half;
   logic [14:0] cnt_reg;
   logic [14:0] cnt_next;
   logic        clk_reg;
   logic        clk_next;
   logic        tick_reg;
   logic        tick_next;

   // half period in source cycles; a divisor below two still gives one
   always_comb begin
      half = div.divisor[15:1];
      if (half == 15'h0000) begin
         half = 15'h0001;
      end
      cnt_next = cnt_reg + 15'h0001;
      clk_next = clk_reg;
      tick_next = 1'b0;
      // >= so a smaller divisor written mid-period takes effect at once
      if (cnt_reg >= half - 15'h0001) begin
         cnt_next = 15'h0000;
         clk_next = ~clk_reg;
         tick_next = ~clk_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 15'h0000;
         clk_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         clk_reg <= clk_next;
         tick_reg <= tick_next;
      end
   end

   assign div.sample_clk = clk_reg;
   assign div.sample_tick = tick_reg;

   property p_tick_rise;
      @(posedge clk) disable iff (rst)
      $rose(clk_reg) |-> tick_reg;
   endproperty
   a_tick_rise: assert property (p_tick_rise)
      else $error("tick not aligned with sampling clock rise");
endmodule
`default_nettype wire

// ==== logic/atcc_top.sv ====
// control registers, trigger detection and post-trigger counter
`timescale 1ns/1ps
`default_nettype none
// Operation
// - bits 3..0 enable channels 0..3; higher bits are ignored
// - sampling clock is the source clock divided, taken straight from the divider
// - 16-bit divisor, bit 0 forced to zero; host never writes below two
// - mode 0 software, 1 post, 2 pre, 3 delay, 4 middle
// - any other mode code means no samples are taken
// - trigger condition is 8-bit level plus slope from the origin register
// - level is offset binary: 0x80 zero, 0x00 negative full scale
// - origin 0..3 picks an analog channel; top bit set picks external input
// - slope 0 triggers on rising crossing, 1 on falling crossing
// - external input uses slope as edge select and ignores the level
// - 16-bit down counter loaded whenever its register is written
// - after trigger counter decrements per sampling clock rise, halts at zero
// - counter sets delay length and middle mode post-trigger sample count
// - trigger seen flag sets on trigger; a one on the clear input clears it
// - done flag reads one exactly while the counter is zero
module atcc_top #(
   parameter int SAMPLE_W = 12
) (
   input  wire logic                                   clk,
   input  wire logic                                   rst,
   input  wire logic                                   reg_wr_en,
   input  wire logic [atcc_pkg::ADDR_W-1:0]            reg_wr_addr,
   input  wire logic [atcc_pkg::DATA_W-1:0]            reg_wr_data,
   input  wire logic                                   reg_rd_en,
   output logic [atcc_pkg::DATA_W-1:0]                 reg_rd_data,
   input  wire logic [atcc_pkg::CHAN_N-1:0][SAMPLE_W-1:0] adc_sample,
   input  wire logic                                   external_edge_input,
   input  wire logic                                   acq_enable,
   input  wire logic                                   clear_trigger_seen,
   output logic [atcc_pkg::CHAN_N-1:0]                 chan_on,
   output logic                                        sample_clk,
   output logic [atcc_pkg::MODE_W-1:0]                 trigger_mode_code,
   output logic                                        mode_valid,
   output logic                                        trigger_event,
   output logic                                        trigger_seen_flag,
   output logic                                        countdown_done_flag,
   output logic [atcc_pkg::COUNT_W-1:0]                after_trigger_count,
   output logic                                        capture_enable
);
   import atcc_pkg::*;

   atcc_div_if div_bus ();

   atcc_sample_divider u_div (
      .clk (clk),
      .rst (rst),
      .div (div_bus)
   );

   // register file
   logic [3:0]  chan_reg, chan_next;
   logic [15:0] div_reg, div_next;
   logic [2:0]  mode_reg, mode_next;
   logic [7:0]  level_reg, level_next;
   logic [2:0]  origin_reg, origin_next;
   logic        slope_reg, slope_next;
   logic [15:0] preload_reg, preload_next;
   logic        count_wr;

   // trigger and counter state
   logic [SAMPLE_W-1:0] s1_reg [CHAN_N];
   logic [SAMPLE_W-1:0] s2_reg [CHAN_N];
   logic        ext1_reg, ext2_reg, ext3_reg;
   logic [7:0]  cur_reg, cur_next;
   logic        prime_reg, prime_next;
   logic        seen_reg, seen_next;
   logic        event_reg, event_next;
   logic [15:0] cnt_reg, cnt_next;
   logic        cap_reg, cap_next;
   logic        tick;
   logic        ext_sel;
   logic        armed;
   logic [7:0]  new_top;
   logic        ana_hit;
   logic        ext_hit;
   logic        hit;
   logic        valid_mode;

   assign tick = div_bus.sample_tick;

   // decode writes; unmatched offsets change nothing
   always_comb begin
      chan_next = chan_reg;
      div_next = div_reg;
      mode_next = mode_reg;
      level_next = level_reg;
      origin_next = origin_reg;
      slope_next = slope_reg;
      preload_next = preload_reg;
      count_wr = 1'b0;
      if (reg_wr_en) begin
         unique case (reg_wr_addr)
            OFF_CHAN: begin
               chan_next = reg_wr_data[CHAN_LSB +: CHAN_N];
            end
            OFF_DIV: begin
               div_next = {reg_wr_data[DIV_LSB+1 +: DIV_W-1], 1'b0};
            end
            OFF_MODE: begin
               mode_next = reg_wr_data[MODE_LSB +: MODE_W];
            end
            OFF_LEVEL: begin
               level_next = reg_wr_data[LEVEL_LSB +: LEVEL_W];
            end
            OFF_ORIGIN: begin
               origin_next = reg_wr_data[ORIGIN_LSB +: ORIGIN_W];
               slope_next = reg_wr_data[SLOPE_BIT];
            end
            OFF_COUNT: begin
               preload_next = reg_wr_data[COUNT_LSB +: COUNT_W];
               count_wr = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chan_reg <= RST_CHAN;
         div_reg <= RST_DIV;
         mode_reg <= MODE_SOFT;
         level_reg <= RST_LEVEL;
         origin_reg <= RST_ORIGIN;
         slope_reg <= RST_SLOPE;
         preload_reg <= RST_COUNT;
      end else begin
         chan_reg <= chan_next;
         div_reg <= div_next;
         mode_reg <= mode_next;
         level_reg <= level_next;
         origin_reg <= origin_next;
         slope_reg <= slope_next;
         preload_reg <= preload_next;
      end
   end

   // samples and external input come from outside; two flops before use
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < CHAN_N; i++) begin
            s1_reg[i] <= '0;
            s2_reg[i] <= '0;
         end
         ext1_reg <= 1'b0;
         ext2_reg <= 1'b0;
         ext3_reg <= 1'b0;
      end else begin
         for (int i = 0; i < CHAN_N; i++) begin
            s1_reg[i] <= adc_sample[i];
            s2_reg[i] <= s1_reg[i];
         end
         ext1_reg <= external_edge_input;
         ext2_reg <= ext1_reg;
         ext3_reg <= ext2_reg;
      end
   end

   // mode decode; undefined codes stop acquisition
   always_comb begin
      unique case (mode_reg)
         MODE_SOFT, MODE_POST, MODE_PRE, MODE_DELAY, MODE_MIDDLE: begin
            valid_mode = 1'b1;
         end
         default: begin
            valid_mode = 1'b0;
         end
      endcase
   end

   // trigger detection; level and sample tops are both offset binary
   // so plain unsigned compare orders them correctly
   always_comb begin
      ext_sel = origin_reg[EXT_SEL_BIT];
      new_top = s2_reg[origin_reg[1:0]][SAMPLE_W-1 -: 8];
      armed = acq_enable && valid_mode && (mode_reg != MODE_SOFT) && !seen_reg;
      if (!slope_reg) begin
         ana_hit = (cur_reg < level_reg) && (new_top >= level_reg);
      end else begin
         ana_hit = (cur_reg >= level_reg) && (new_top < level_reg);
      end
      ana_hit = ana_hit && tick && prime_reg;
      // level plays no part for the external input
      ext_hit = slope_reg ? (!ext2_reg && ext3_reg) : (ext2_reg && !ext3_reg);
      hit = armed && (ext_sel ? ext_hit : ana_hit);
      cur_next = tick ? new_top : cur_reg;
      prime_next = armed && (prime_reg || tick);
      event_next = hit;
      // set wins over a clear in the same cycle
      seen_next = hit || (seen_reg && !clear_trigger_seen);
   end

   // post-trigger counter; a register write outranks a decrement
   always_comb begin
      cnt_next = cnt_reg;
      if (count_wr) begin
         cnt_next = preload_next;
      end else if (seen_reg && tick && (cnt_reg != 16'h0000)) begin
         cnt_next = cnt_reg - 16'h0001;
      end
   end

   // capture window per mode, counter reaching zero opens the delay window and ends the middle window
   always_comb begin
      cap_next = 1'b0;
      if (acq_enable) begin
         unique case (mode_reg)
            MODE_SOFT: cap_next = 1'b1;
            MODE_POST: cap_next = seen_reg;
            MODE_PRE: cap_next = !seen_reg;
            MODE_DELAY: cap_next = seen_reg && (cnt_reg == 16'h0000);
            MODE_MIDDLE: cap_next = !seen_reg || (cnt_reg != 16'h0000);
            default: cap_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur_reg <= RST_LEVEL;
         prime_reg <= 1'b0;
         seen_reg <= 1'b0;
         event_reg <= 1'b0;
         cnt_reg <= RST_COUNT;
         cap_reg <= 1'b0;
      end else begin
         cur_reg <= cur_next;
         prime_reg <= prime_next;
         seen_reg <= seen_next;
         event_reg <= event_next;
         cnt_reg <= cnt_next;
         cap_reg <= cap_next;
      end
   end

   assign div_bus.divisor = div_reg;
   assign sample_clk = div_bus.sample_clk;
   assign chan_on = chan_reg;
   assign trigger_mode_code = mode_reg;
   assign mode_valid = valid_mode;
   assign trigger_event = event_reg;
   assign trigger_seen_flag = seen_reg;
   assign countdown_done_flag = (cnt_reg == 16'h0000);
   assign after_trigger_count = cnt_reg;
   assign capture_enable = cap_reg;
   // write-only registers: reads see zero
   assign reg_rd_data = READ_VALUE;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_cross_up;
      armed && !ext_sel && !slope_reg && tick && prime_reg
         && cur_reg < level_reg && new_top >= level_reg;
   endsequence

   property p_chan_write;
      reg_wr_en && reg_wr_addr == OFF_CHAN |=> chan_on == $past(reg_wr_data[3:0]);
   endproperty
   a_chan_write: assert property (p_chan_write)
      else $error("channel enables not taken from low bits");

   property p_div_lsb;
      reg_wr_en && reg_wr_addr == OFF_DIV |=> div_reg == {$past(reg_wr_data[15:1]), 1'b0};
   endproperty
   a_div_lsb: assert property (p_div_lsb)
      else $error("divisor bit zero not forced low");

   property p_bad_mode;
      reg_wr_en && reg_wr_addr == OFF_MODE && reg_wr_data[2:0] > 3'h4 |=> ##1 !capture_enable;
   endproperty
   a_bad_mode: assert property (p_bad_mode)
      else $error("capture with undefined mode");

   property p_cross_up;
      s_cross_up |=> trigger_event && trigger_seen_flag;
   endproperty
   a_cross_up: assert property (p_cross_up)
      else $error("rising crossing did not trigger");

   property p_ext_fall;
      armed && ext_sel && slope_reg && $fell(ext2_reg) |=> trigger_event;
   endproperty
   a_ext_fall: assert property (p_ext_fall)
      else $error("falling external edge missed");

   property p_clear;
      seen_reg && clear_trigger_seen && !hit |=> !trigger_seen_flag;
   endproperty
   a_clear: assert property (p_clear)
      else $error("trigger flag not cleared");

   property p_load;
      count_wr |=> after_trigger_count == $past(reg_wr_data[15:0]);
   endproperty
   a_load: assert property (p_load)
      else $error("counter not loaded on write");

   property p_dec;
      seen_reg && tick && cnt_reg != 16'h0000 && !count_wr
         |=> after_trigger_count == $past(cnt_reg) - 16'h0001;
   endproperty
   a_dec: assert property (p_dec)
      else $error("counter did not decrement");

   property p_halt;
      countdown_done_flag && !count_wr |=> countdown_done_flag && after_trigger_count == 16'h0000;
   endproperty
   a_halt: assert property (p_halt)
      else $error("counter left zero without a write");

   property p_read_zero;
      reg_rd_en |-> reg_rd_data == 32'h0000_0000;
   endproperty
   a_read_zero: assert property (p_read_zero)
      else $error("write-only register returned data");
endmodule
`default_nettype wire

// ==== sim/atcc_adc_model.sv ====
// converter channels and external trigger pin as seen from the sample side
`timescale 1ns/1ps
`default_nettype none
module atcc_adc_model (
   input  wire logic             clk,
   input  wire logic [3:0][11:0] want,
   input  wire logic             ext_want,
   output var logic  [3:0][11:0] adc_sample,
   output var logic              external_edge_input
);
   // a converter word lands one source clock after the analog value settles;
   // the first edge comes well inside reset, so no unknown leaves the synchronisers
   always @(posedge clk) begin
      adc_sample <= want;
      external_edge_input <= ext_want;
   end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the trigger and sampling clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import atcc_pkg::*;
   logic                  clk;
   logic                  rst;
   logic                  reg_wr_en;
   logic [ADDR_W-1:0]     reg_wr_addr;
   logic [DATA_W-1:0]     reg_wr_data;
   logic                  reg_rd_en;
   logic [DATA_W-1:0]     reg_rd_data;
   logic [3:0][11:0]      adc_sample;
   logic [3:0][11:0]      ch_want;
   logic                  ext_want;
   logic                  external_edge_input;
   logic                  acq_enable;
   logic                  clear_trigger_seen;
   logic [3:0]            chan_on;
   logic                  sample_clk;
   logic [2:0]            trigger_mode_code;
   logic                  mode_valid;
   logic                  trigger_event;
   logic                  trigger_seen_flag;
   logic                  countdown_done_flag;
   logic [15:0]           after_trigger_count;
   logic                  capture_enable;
   logic [3:0]            pats [4];
   int                    n_fail;
   int                    num_checks;
   int                    cyc = 0;
   int                    k;

   atcc_top #(.SAMPLE_W(12)) u_dut (
      .clk(clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
      .adc_sample(adc_sample), .external_edge_input(external_edge_input),
      .acq_enable(acq_enable), .clear_trigger_seen(clear_trigger_seen), .chan_on(chan_on),
      .sample_clk(sample_clk), .trigger_mode_code(trigger_mode_code), .mode_valid(mode_valid),
      .trigger_event(trigger_event), .trigger_seen_flag(trigger_seen_flag),
      .countdown_done_flag(countdown_done_flag), .after_trigger_count(after_trigger_count),
      .capture_enable(capture_enable)
   );
   atcc_adc_model u_adc (
      .clk(clk), .want(ch_want), .ext_want(ext_want), .adc_sample(adc_sample),
      .external_edge_input(external_edge_input)
   );

   // free running source clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // cut a hang short; the tests need well under two thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one write per strobe, held across the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      reg_wr_en = 1'b1;
      reg_wr_addr = a;
      reg_wr_data = d;
      @(negedge clk);
      reg_wr_en = 1'b0;
   endtask

   task automatic hold_lvl(input logic v, inout int p);
      while (sample_clk === v && p < 100) begin
         @(negedge clk);
         p++;
      end
   endtask

   // full sampling clock period in source cycles, measured rise to rise
   task automatic period(output int p);
      p = 0;
      hold_lvl(1'b1, p);
      hold_lvl(1'b0, p);
      p = 0;
      hold_lvl(1'b1, p);
      hold_lvl(1'b0, p);
   endtask

   // bounded wait: which 0 waits for the seen flag, 1 for the done flag
   task automatic wait_sig(input int which, output int c);
      c = 0;
      while ((which == 1 ? countdown_done_flag : trigger_seen_flag) !== 1'b1 && c < 60) begin
         @(negedge clk);
         c++;
      end
   endtask

   initial begin
      rst = 1'b1;
      reg_wr_en = 1'b0;
      reg_wr_addr = 8'h00;
      reg_wr_data = 32'h0000_0000;
      reg_rd_en = 1'b0;
      acq_enable = 1'b0;
      clear_trigger_seen = 1'b0;
      ext_want = 1'b0;
      ch_want = {4{12'hC00}};
      n_fail = 0;
      num_checks = 0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      chk_val(after_trigger_count, 32'h0000_0000);
      chk_bit(countdown_done_flag, 1'b1);
      chk_bit(trigger_seen_flag, 1'b0);
      chk_bit(mode_valid, 1'b1);
      // reads of the write-only space give nothing back
      @(negedge clk);
      reg_rd_en = 1'b1;
      @(negedge clk);
      chk_val(reg_rd_data, READ_VALUE);
      reg_rd_en = 1'b0;
      $display("test reset and read done");

      // only the low four bits count, whatever sits above them
      pats = '{4'h0, 4'h1, 4'h3, 4'hF};
      foreach (pats[i]) begin
         wr(OFF_CHAN, {28'hABC_DEF0, pats[i]});
         chk_val(chan_on, pats[i]);
      end
      wr(8'h18, 32'h0000_0000);
      chk_val(chan_on, 4'hF);
      $display("test channel enables done");

      // reset divisor 2, then odd value rounded down, then 8
      period(k);
      chk_val(k, 32'h0000_0002);
      wr(OFF_DIV, 32'hFFFF_0005);
      period(k);
      chk_val(k, 32'h0000_0004);
      wr(OFF_DIV, 32'h0000_0008);
      period(k);
      chk_val(k, 32'h0000_0008);
      $display("test divider done");

      // every mode code; capture window before any trigger is 1 for soft, pre, middle
      acq_enable = 1'b1;
      for (int m = 0; m < 8; m++) begin
         wr(OFF_MODE, {29'h1FFF_FFFF, m[2:0]});
         @(negedge clk);
         chk_val(trigger_mode_code, m[2:0]);
         chk_bit(mode_valid, m < 5);
         chk_bit(capture_enable, m == 0 || m == 2 || m == 4);
      end
      $display("test mode codes done");

      // external rising edge in delay mode; a full-scale level must not matter
      wr(OFF_DIV, 32'h0000_0004);
      wr(OFF_LEVEL, 32'h0000_00FF);
      wr(OFF_ORIGIN, 32'h0000_0004);
      wr(OFF_COUNT, 32'hFFFF_0003);
      chk_val(after_trigger_count, 32'h0000_0003);
      chk_bit(countdown_done_flag, 1'b0);
      wr(OFF_MODE, 32'h0000_0003);
      repeat (20) @(negedge clk);
      chk_bit(trigger_seen_flag, 1'b0);
      chk_val(after_trigger_count, 32'h0000_0003);
      ext_want = 1'b1;
      wait_sig(0, k);
      chk_bit(trigger_seen_flag, 1'b1);
      chk_bit(trigger_event, 1'b1);
      chk_bit(capture_enable, 1'b0);
      wait_sig(1, k);
      chk_bit(k >= 8 && k <= 13, 1'b1);
      @(negedge clk);
      chk_bit(capture_enable, 1'b1);
      repeat (12) @(negedge clk);
      chk_val(after_trigger_count, 32'h0000_0000);
      @(negedge clk);
      clear_trigger_seen = 1'b1;
      @(negedge clk);
      clear_trigger_seen = 1'b0;
      chk_bit(trigger_seen_flag, 1'b0);
      $display("test external delay trigger done");

      // analog falling crossing on channel 1 in middle mode
      wr(OFF_COUNT, 32'h0000_0002);
      chk_val(after_trigger_count, 32'h0000_0002);
      wr(OFF_LEVEL, 32'h0000_0080);
      wr(OFF_ORIGIN, 32'h0000_0009);
      wr(OFF_MODE, 32'h0000_0004);
      repeat (10) @(negedge clk);
      ch_want[0] = 12'h400;
      repeat (20) @(negedge clk);
      chk_bit(trigger_seen_flag, 1'b0);
      chk_bit(capture_enable, 1'b1);
      ch_want[1] = 12'h7F0;
      wait_sig(0, k);
      chk_bit(trigger_seen_flag, 1'b1);
      chk_bit(trigger_event, 1'b1);
      wait_sig(1, k);
      chk_val(after_trigger_count, 32'h0000_0000);
      repeat (2) @(negedge clk);
      chk_bit(capture_enable, 1'b0);
      $display("test analog middle trigger done");

      // falling external edge in post mode; the window opens a cycle after the flag
      clear_trigger_seen = 1'b1;
      @(negedge clk);
      clear_trigger_seen = 1'b0;
      chk_bit(trigger_seen_flag, 1'b0);
      wr(OFF_ORIGIN, 32'h0000_000C);
      wr(OFF_MODE, 32'h0000_0001);
      repeat (8) @(negedge clk);
      chk_bit(trigger_seen_flag, 1'b0);
      ext_want = 1'b0;
      wait_sig(0, k);
      chk_bit(trigger_event, 1'b1);
      chk_bit(capture_enable, 1'b0);
      @(negedge clk);
      chk_bit(trigger_event, 1'b0);
      chk_bit(capture_enable, 1'b1);
      $display("test external falling edge done");

      // rising crossing on channel 0 in pre mode; the window closes on the trigger
      wr(OFF_ORIGIN, 32'h0000_0000);
      wr(OFF_MODE, 32'h0000_0002);
      clear_trigger_seen = 1'b1;
      @(negedge clk);
      clear_trigger_seen = 1'b0;
      repeat (12) @(negedge clk);
      chk_bit(trigger_seen_flag, 1'b0);
      chk_bit(capture_enable, 1'b1);
      ch_want[0] = 12'h900;
      wait_sig(0, k);
      chk_bit(trigger_event, 1'b1);
      repeat (2) @(negedge clk);
      chk_bit(capture_enable, 1'b0);
      $display("test analog rising pre trigger done");
      summarize();
   end
endmodule
`default_nettype wire
